// ==== include/rcc_pkg.sv ====
/*
 Package for the ratio and output configuration block: register offsets,
 field positions, reset values, source codes and the carrier structs.
 Assumes a byte-wide register write/read port fed by the serial control port.
*/
package rcc_pkg;
   // Register offsets (byte addresses of the control port)
   localparam logic [7:0] ADDR_OUT_CTRL = 8'h02;
   localparam logic [7:0] ADDR_CFG1 = 8'h03;
   localparam logic [7:0] ADDR_RATIO0 = 8'h06;
   localparam logic [7:0] ADDR_RATIO3 = 8'h09;
   localparam logic [7:0] ADDR_STATUS = 8'h0b;
   localparam logic [7:0] ADDR_FUNC_CFG = 8'h16;

   // Field positions
   localparam int OUT_MAIN_DIS_BIT = 0;
   localparam int OUT_AUX_DIS_BIT = 1;
   localparam int CFG1_RMOD_LSB = 5;
   localparam int CFG1_AUX_LSB = 1;
   localparam int FUNC_ALLOW_BIT = 0;
   localparam int FUNC_DIV_LSB = 3;
   localparam int FUNC_STYLE_BIT = 6;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_VALID_BIT = 1;

   // Ratio format: 12 integer bits over 20 fractional bits
   localparam int RATIO_W = 32;
   localparam int FRACN_W = 34;
   localparam logic [RATIO_W-1:0] RATIO_RST = 32'h0000_0000;
   localparam logic [3:0] RATIO_ALL_BYTES = 4'hf;

   // Modifier, divider and aux source codes
   localparam logic [2:0] RMOD_RST = 3'h0;
   localparam logic [1:0] DIV_RST = 2'h0;
   localparam logic [1:0] DIV_BY4 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] AUX_SRC_RST = 2'h0;
   localparam logic [1:0] AUX_SRC_SYNTH = 2'h2;
   localparam logic [1:0] AUX_SRC_LOCK = 2'h3;

   typedef enum logic [1:0] {AUX_REF, AUX_SYNTH, AUX_LOCK} rcc_aux_e;

   // Software settings travel together
   typedef struct packed {
      logic [2:0] ratio_modifier_sel;
      logic [1:0] ref_divider_sel;
      logic [1:0] aux_source_sel;
      logic main_output_disable;
      logic aux_output_disable;
      logic unlocked_output_allow;
      logic lock_pin_style;
   } rcc_cfg_s;

   localparam rcc_cfg_s CFG_RST = '{ratio_modifier_sel: RMOD_RST, ref_divider_sel: DIV_RST,
      aux_source_sel: AUX_SRC_RST, main_output_disable: 1'b0, aux_output_disable: 1'b0,
      unlocked_output_allow: 1'b0, lock_pin_style: 1'b0};

   // Asynchronous inputs sampled together
   typedef struct packed {
      logic ref_clk;
      logic synth_clk;
      logic locked;
   } rcc_pins_s;

   localparam rcc_pins_s PINS_RST = '{ref_clk: 1'b0, synth_clk: 1'b0, locked: 1'b0};
endpackage

// ==== logic/rcc_ratio_out.sv ====
/*
 Ratio and output configuration of a fractional-N clock synthesizer:
 register file, effective ratio and fractional-N value, main and auxiliary
 output routing with glitch-free gating.
 Assumes the reference, synthesized clock and lock flag arrive from outside
 the clk domain and are much slower than clk; register accesses come from the
 control port logic as single-cycle byte strobes on clk.
*/
// Notes on behaviour
// R1 - Software picks the reference divider so the internal timing clock is in range.
// R2 - User ratio is unsigned 32-bit, 12 integer bits over 20 fraction bits.
// R3 - Reference divider is compensated inside; software writes the plain ratio.
// R4 - Modifier codes 000..011 multiply 1,2,4,8; 100..111 give 0.5 to 0.0625.
// R5 - Modifier selection resets to 000, a multiplier of one.
// R6 - Selected modifier is always applied, even when it is one.
// R7 - Applying the modifier never changes the stored user ratio.
// R8 - Effective ratio is user ratio times modifier and drives the fractional-N value.
// R9 - Software must not pick a modifier that overflows or truncates the ratio.
// R10 - Main output disable puts the main clock driver in high impedance.
// R11 - While unlocked the main output is held low by default.
// R12 - Unlocked-output-allow lets the main output follow the synthesizer when unlocked.
// R13 - Aux source selects reference, synthesized clock copy or lock indicator.
// R14 - Lock pin style sets driver type and polarity of the lock indicator.
// R15 - Aux copy of the synthesized clock need not be in phase with main output.
// R16 - Aux output disable puts the aux driver in high impedance.
// R17 - Enables, aux clock source changes and unlock gating never make runt periods.
// R18 - Any change of the fractional-N value forces the loop to relock.
// R19 - After power-up output pins stay low until a valid ratio is written.
// R20 - Modifier multiplication is a binary shift of the user ratio.
`timescale 1ns/10ps
module rcc_ratio_out (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port from the control port logic
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_addr,
   output logic [7:0] reg_rd_data,
   // Signals from the analog loop and reference
   input wire logic timing_reference_clock,
   input wire logic synth_clk,
   input wire logic pll_locked,
   // Loop control
   output logic [rcc_pkg::FRACN_W-1:0] frac_n_value,
   output logic relock_req,
   // Main clock pin
   output logic clk_out_o,
   output logic clk_out_oe,
   // Auxiliary pin
   output logic aux_out_o,
   output logic aux_out_oe
);

   // Effective ratio: shift left for x2..x8, right for /2../16
   function automatic logic [rcc_pkg::RATIO_W-1:0] eff_ratio(input logic [rcc_pkg::RATIO_W-1:0] r,
                                                           input logic [2:0] sel);
      logic [1:0] amt;
      amt = sel[1:0];
      if (sel[2]) begin
         eff_ratio = r >> ({1'b0, amt} + 3'h1); // [R4] [R20]
      end else begin
         eff_ratio = r << amt; // [R4] [R20]
      end
   endfunction

   // Multiply back by the reference divider so software never corrects for it
   function automatic logic [rcc_pkg::FRACN_W-1:0] div_comp(input logic [rcc_pkg::RATIO_W-1:0] e,
                                                          input logic [1:0] div);
      logic [rcc_pkg::FRACN_W-1:0] w;
      w = {2'h0, e};
      if (div == rcc_pkg::DIV_BY4) begin
         div_comp = w << 2; // [R3]
      end else if (div == rcc_pkg::DIV_BY2) begin
         div_comp = w << 1; // [R3]
      end else begin
         div_comp = w;
      end
   endfunction

   function automatic rcc_pkg::rcc_aux_e aux_decode(input logic [1:0] src);
      if (src == rcc_pkg::AUX_SRC_LOCK) begin
         aux_decode = rcc_pkg::AUX_LOCK;
      end else if (src == rcc_pkg::AUX_SRC_SYNTH) begin
         aux_decode = rcc_pkg::AUX_SYNTH;
      end else begin
         aux_decode = rcc_pkg::AUX_REF;
      end
   endfunction

   // Input synchroniser and agreement filter
   rcc_pkg::rcc_pins_s s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

   always_comb begin
      filt_next = filt_reg;
      if (s2_reg.ref_clk == s3_reg.ref_clk) begin
         filt_next.ref_clk = s2_reg.ref_clk;
      end
      if (s2_reg.synth_clk == s3_reg.synth_clk) begin
         filt_next.synth_clk = s2_reg.synth_clk;
      end
      if (s2_reg.locked == s3_reg.locked) begin
         filt_next.locked = s2_reg.locked;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_reg <= rcc_pkg::PINS_RST;
         s2_reg <= rcc_pkg::PINS_RST;
         s3_reg <= rcc_pkg::PINS_RST;
         filt_reg <= rcc_pkg::PINS_RST;
      end else begin
         s1_reg <= '{ref_clk: timing_reference_clock, synth_clk: synth_clk, locked: pll_locked};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   // Register file; ratio bytes are most significant first
   rcc_pkg::rcc_cfg_s cfg_reg, cfg_next;
   logic [rcc_pkg::RATIO_W-1:0] user_ratio_reg, user_ratio_next;
   logic [3:0] ratio_seen_reg, ratio_seen_next;
   logic [7:0] rd_data_reg, rd_data_next;
   logic ratio_valid;
   logic [1:0] byte_idx;

   assign ratio_valid = (ratio_seen_reg == rcc_pkg::RATIO_ALL_BYTES);
   assign byte_idx = 2'(rcc_pkg::ADDR_RATIO3 - reg_wr_addr);

   always_comb begin
      cfg_next = cfg_reg;
      user_ratio_next = user_ratio_reg;
      ratio_seen_next = ratio_seen_reg;
      if (reg_wr_en) begin
         if (reg_wr_addr >= rcc_pkg::ADDR_RATIO0 && reg_wr_addr <= rcc_pkg::ADDR_RATIO3) begin
            user_ratio_next[byte_idx*8 +: 8] = reg_wr_data; // [R2]
            ratio_seen_next[byte_idx] = 1'b1; // [R19]
         end else if (reg_wr_addr == rcc_pkg::ADDR_OUT_CTRL) begin
            cfg_next.main_output_disable = reg_wr_data[rcc_pkg::OUT_MAIN_DIS_BIT];
            cfg_next.aux_output_disable = reg_wr_data[rcc_pkg::OUT_AUX_DIS_BIT];
         end else if (reg_wr_addr == rcc_pkg::ADDR_CFG1) begin
            cfg_next.ratio_modifier_sel = reg_wr_data[rcc_pkg::CFG1_RMOD_LSB +: 3];
            cfg_next.aux_source_sel = reg_wr_data[rcc_pkg::CFG1_AUX_LSB +: 2];
         end else if (reg_wr_addr == rcc_pkg::ADDR_FUNC_CFG) begin
            cfg_next.unlocked_output_allow = reg_wr_data[rcc_pkg::FUNC_ALLOW_BIT];
            cfg_next.ref_divider_sel = reg_wr_data[rcc_pkg::FUNC_DIV_LSB +: 2];
            cfg_next.lock_pin_style = reg_wr_data[rcc_pkg::FUNC_STYLE_BIT];
         end
      end
      // Read mux; unmapped offsets read as zero
      rd_data_next = 8'h00;
      if (reg_rd_addr >= rcc_pkg::ADDR_RATIO0 && reg_rd_addr <= rcc_pkg::ADDR_RATIO3) begin
         rd_data_next = user_ratio_reg[2'(rcc_pkg::ADDR_RATIO3 - reg_rd_addr)*8 +: 8]; // [R7]
      end else if (reg_rd_addr == rcc_pkg::ADDR_OUT_CTRL) begin
         rd_data_next[rcc_pkg::OUT_MAIN_DIS_BIT] = cfg_reg.main_output_disable;
         rd_data_next[rcc_pkg::OUT_AUX_DIS_BIT] = cfg_reg.aux_output_disable;
      end else if (reg_rd_addr == rcc_pkg::ADDR_CFG1) begin
         rd_data_next[rcc_pkg::CFG1_RMOD_LSB +: 3] = cfg_reg.ratio_modifier_sel;
         rd_data_next[rcc_pkg::CFG1_AUX_LSB +: 2] = cfg_reg.aux_source_sel;
      end else if (reg_rd_addr == rcc_pkg::ADDR_FUNC_CFG) begin
         rd_data_next[rcc_pkg::FUNC_ALLOW_BIT] = cfg_reg.unlocked_output_allow;
         rd_data_next[rcc_pkg::FUNC_DIV_LSB +: 2] = cfg_reg.ref_divider_sel;
         rd_data_next[rcc_pkg::FUNC_STYLE_BIT] = cfg_reg.lock_pin_style;
      end else if (reg_rd_addr == rcc_pkg::ADDR_STATUS) begin
         rd_data_next[rcc_pkg::STAT_LOCK_BIT] = filt_reg.locked;
         rd_data_next[rcc_pkg::STAT_VALID_BIT] = ratio_valid;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_reg <= rcc_pkg::CFG_RST; // [R5]
         user_ratio_reg <= rcc_pkg::RATIO_RST;
         ratio_seen_reg <= 4'h0;
         rd_data_reg <= 8'h00;
      end else begin
         cfg_reg <= cfg_next;
         user_ratio_reg <= user_ratio_next;
         ratio_seen_reg <= ratio_seen_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign reg_rd_data = rd_data_reg;

   // Fractional-N value; software must keep the product inside 12.20 [R9]
   logic [rcc_pkg::RATIO_W-1:0] effective_ratio;
   logic [rcc_pkg::FRACN_W-1:0] fracn_reg, fracn_next;
   logic relock_reg, relock_next;

   always_comb begin
      effective_ratio = eff_ratio(user_ratio_reg, cfg_reg.ratio_modifier_sel); // [R6] [R8]
      fracn_next = div_comp(effective_ratio, cfg_reg.ref_divider_sel); // [R8]
      relock_next = (fracn_next != fracn_reg); // [R18]
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fracn_reg <= '0;
         relock_reg <= 1'b0;
      end else begin
         fracn_reg <= fracn_next;
         relock_reg <= relock_next;
      end
   end

   assign frac_n_value = fracn_reg;
   assign relock_req = relock_reg;

   // Main output: gate and enable only move while the clock is low, so no runt
   logic main_gate_reg, main_gate_next, main_oe_reg, main_oe_next, clk_out_reg, clk_out_next;

   always_comb begin
      main_gate_next = main_gate_reg;
      main_oe_next = main_oe_reg;
      if (!ratio_valid) begin
         main_gate_next = 1'b0; // [R19]
         main_oe_next = 1'b1; // [R19]
      end else if (!filt_reg.synth_clk) begin
         main_gate_next = filt_reg.locked || cfg_reg.unlocked_output_allow; // [R11] [R12] [R17]
         main_oe_next = !cfg_reg.main_output_disable; // [R10] [R17]
      end
      clk_out_next = main_gate_reg && filt_reg.synth_clk;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         main_gate_reg <= 1'b0;
         main_oe_reg <= 1'b1;
         clk_out_reg <= 1'b0;
      end else begin
         main_gate_reg <= main_gate_next;
         main_oe_reg <= main_oe_next;
         clk_out_reg <= clk_out_next;
      end
   end

   assign clk_out_o = clk_out_reg;
   assign clk_out_oe = main_oe_reg;

   // Aux routing; clock sources swap only when both are low. The aux copy is
   // re-timed through one register from the same filtered input as the main pin, so it stays in phase with it [R15]
   rcc_pkg::rcc_aux_e aux_cur_reg, aux_cur_next, aux_want;
   logic aux_en_reg, aux_en_next, aux_out_reg, aux_out_next, aux_oe_reg, aux_oe_next;
   logic cur_level, want_level;

   function automatic logic src_level(input rcc_pkg::rcc_aux_e s, input rcc_pkg::rcc_pins_s p);
      case (s)
         rcc_pkg::AUX_SYNTH: src_level = p.synth_clk;
         rcc_pkg::AUX_LOCK: src_level = !p.locked;
         default: src_level = p.ref_clk;
      endcase
   endfunction

   always_comb begin
      aux_want = aux_decode(cfg_reg.aux_source_sel); // [R13]
      cur_level = src_level(aux_cur_reg, filt_reg);
      want_level = src_level(aux_want, filt_reg);
      aux_cur_next = aux_cur_reg;
      aux_en_next = aux_en_reg;
      // The lock indicator is a level, so switching to or from it is immediate
      if (aux_cur_reg == rcc_pkg::AUX_LOCK || aux_want == rcc_pkg::AUX_LOCK || (!cur_level && !want_level)) begin
         aux_cur_next = aux_want; // [R17]
      end
      if (aux_cur_reg == rcc_pkg::AUX_LOCK || !cur_level) begin
         aux_en_next = !cfg_reg.aux_output_disable; // [R16] [R17]
      end
      if (!ratio_valid) begin
         aux_out_next = 1'b0; // [R19]
         aux_oe_next = 1'b1; // [R19]
      end else if (aux_cur_reg == rcc_pkg::AUX_LOCK && cfg_reg.lock_pin_style) begin
         aux_out_next = 1'b0; // [R14] open drain, pulled low while unlocked
         aux_oe_next = aux_en_reg && !filt_reg.locked; // [R14]
      end else begin
         aux_out_next = cur_level; // [R14] push-pull, high while unlocked
         aux_oe_next = aux_en_reg; // [R16]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aux_cur_reg <= rcc_pkg::AUX_REF;
         aux_en_reg <= 1'b1;
         aux_out_reg <= 1'b0;
         aux_oe_reg <= 1'b1;
      end else begin
         aux_cur_reg <= aux_cur_next;
         aux_en_reg <= aux_en_next;
         aux_out_reg <= aux_out_next;
         aux_oe_reg <= aux_oe_next;
      end
   end

   assign aux_out_o = aux_out_reg;
   assign aux_out_oe = aux_oe_reg;

   // Checks
   pins_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
      !ratio_valid |=> (!clk_out_o && clk_out_oe && !aux_out_o && aux_out_oe))
      else $error("output not held low before ratio valid");
   unlock_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
      (ratio_valid && !filt_reg.synth_clk && !filt_reg.locked && !cfg_reg.unlocked_output_allow) |=> ##1 !clk_out_o)
      else $error("main output not forced low while unlocked");
   unlock_pass_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
      (ratio_valid && !filt_reg.synth_clk && cfg_reg.unlocked_output_allow) |=> main_gate_reg)
      else $error("main output not released with unlock allow");
   main_hiz_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
      (ratio_valid && !filt_reg.synth_clk && cfg_reg.main_output_disable) |=> !clk_out_oe)
      else $error("main output not high impedance when disabled");
   mod_double_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
      (cfg_reg.ratio_modifier_sel == 3'h1 && cfg_reg.ref_divider_sel == 2'h2)
      |=> frac_n_value == {1'b0, $past(user_ratio_reg), 1'b0})
      else $error("modifier two not applied");
   ratio_kept_a: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
      !$stable(user_ratio_reg) |-> $past(reg_wr_en) && $past(reg_wr_addr) >= rcc_pkg::ADDR_RATIO0 &&
      $past(reg_wr_addr) <= rcc_pkg::ADDR_RATIO3)
      else $error("user ratio changed without a ratio write");
   relock_a: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
      !$stable(frac_n_value) |-> relock_req)
      else $error("fractional-N change without relock request");
   aux_hiz_a: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
      (ratio_valid && aux_cur_reg == rcc_pkg::AUX_LOCK && cfg_reg.aux_output_disable) |=> ##1 !aux_out_oe)
      else $error("aux output not high impedance when disabled");
   lock_od_a: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
      (ratio_valid && aux_cur_reg == rcc_pkg::AUX_LOCK && cfg_reg.lock_pin_style) |=> !aux_out_o)
      else $error("open-drain lock indicator drove high");
   no_runt_a: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
      $fell(clk_out_o) |-> !$past(filt_reg.synth_clk))
      else $error("main output cut while high");
endmodule

// ==== tb/rcc_loop_model.sv ====
/*
 Behavioural model of the analog side: reference clock, synthesized clock
 and lock flag. Assumes the block asks for relock with relock_req on clk.
*/
`timescale 1ns/10ps
module rcc_loop_model #(
   parameter int LOCK_CYC = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control from the block and the bench
   input wire logic relock_req,
   input wire logic hold_unlock,
   // Loop outputs
   output logic ref_clk,
   output logic synth_clk,
   output logic locked
);
   int lock_cnt;

   // Free-running clocks, every edge aligned with a falling edge of clk
   initial begin
      ref_clk = 1'b0;
      synth_clk = 1'b0;
   end
   always #20 ref_clk = ~ref_clk;
   always #30 synth_clk = ~synth_clk;

   // Lock is lost on every new fractional-N value and regained later
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_cnt <= 0;
      end else if (relock_req) begin
         lock_cnt <= 0;
      end else if (lock_cnt != LOCK_CYC) begin
         lock_cnt <= lock_cnt + 1;
      end
   end
   // The bench may hold the loop unlocked to exercise gating
   assign locked = (lock_cnt == LOCK_CYC) && !hold_unlock;
endmodule

// ==== tb/test_ratio_and_output_config.sv ====
/*
 Self-checking bench for the ratio and output configuration block.
 Assumes the loop model drives the analog inputs; inputs change at negedge.
*/
`timescale 1ns/10ps
module test_ratio_and_output_config;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic [7:0] reg_wr_addr = 8'h00;
   logic [7:0] reg_wr_data = 8'h00;
   logic [7:0] reg_rd_addr = 8'h00;
   logic [7:0] reg_rd_data;
   logic ref_clk, synth_clk, pll_locked, relock_req;
   logic clk_out_o, clk_out_oe, aux_out_o, aux_out_oe;
   logic hold_unlock = 1'b0;
   logic [rcc_pkg::FRACN_W-1:0] frac_n_value;
   int err_total = 0;
   int n_checks = 0;
   int relocks = 0;
   int hi_len = 0;
   // Fits every modifier without overflow or lost fraction bits
   localparam logic [31:0] RATIO = 32'h0012_3450;

   always #2.5 clk = ~clk;

   rcc_loop_model LOOP (.clk(clk), .sys_rst(sys_rst), .relock_req(relock_req), .hold_unlock(hold_unlock),
      .ref_clk(ref_clk), .synth_clk(synth_clk), .locked(pll_locked));

   rcc_ratio_out DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
      .timing_reference_clock(ref_clk), .synth_clk(synth_clk), .pll_locked(pll_locked),
      .frac_n_value(frac_n_value), .relock_req(relock_req), .clk_out_o(clk_out_o),
      .clk_out_oe(clk_out_oe), .aux_out_o(aux_out_o), .aux_out_oe(aux_out_oe));

   task automatic fail(input string msg);
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string msg);
      n_checks++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
   endtask

   // Relock pulses and main output high times are watched all run
   always @(posedge clk) begin
      if (relock_req === 1'b1) relocks++;
      if (clk_out_o === 1'b1) hi_len++;
      else begin
         if (hi_len != 0 && hi_len < 3) fail("short high time on main output");
         hi_len = 0;
      end
   end

   // Run time limit so a hang still reaches the verdict
   initial begin
      #200000;
      fail("run time limit");
      results();
   end

   // Expected fractional-N value: modifier shift, then divider compensation
   function automatic logic [33:0] exp_frac(input logic [31:0] r, input logic [2:0] m, input logic [1:0] d);
      logic [31:0] eff;
      eff = m[2] ? (r >> (m[1:0] + 3'h1)) : (r << m[1:0]);
      return {2'b00, eff} << ((d == 2'h0) ? 2 : (d == 2'h1) ? 1 : 0);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // One byte write; an idle cycle follows so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask

   // Read data is registered, so it is taken one cycle after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_rd_addr = a;
      @(negedge clk);
      d = reg_rd_data;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      rd(a, d);
      chk(34'(d), 34'(exp), msg);
   endtask

   // Counts level changes of one pin over 80 cycles
   task automatic edges(input bit aux, output int n);
      logic last;
      n = 0;
      last = aux ? aux_out_o : clk_out_o;
      repeat (80) begin
         @(negedge clk);
         if ((aux ? aux_out_o : clk_out_o) !== last) n++;
         last = aux ? aux_out_o : clk_out_o;
      end
   endtask

   // Waits for lock plus the input synchroniser delay
   task automatic wait_lock;
      int i;
      for (i = 0; i < 400 && pll_locked !== 1'b1; i++) @(negedge clk);
      if (pll_locked !== 1'b1) begin
         fail("lock never came");
         results();
      end
      cyc(10);
   endtask

   task automatic t_reset;
      chk(frac_n_value, 34'h0, "frac at reset");
      chk(34'({clk_out_o, clk_out_oe, aux_out_o, aux_out_oe}), 34'h5, "pins at reset");
      rd_chk(rcc_pkg::ADDR_CFG1, 8'h00, "modifier reset");
      rd_chk(rcc_pkg::ADDR_FUNC_CFG, 8'h00, "func reset");
      rd_chk(rcc_pkg::ADDR_RATIO0, 8'h00, "ratio reset");
      rd_chk(8'h40, 8'h00, "unmapped read");
      $display("t_reset done");
   endtask

   task automatic t_ratio;
      int n, r0, i;
      logic [7:0] d;
      for (i = 0; i < 3; i++) wr(rcc_pkg::ADDR_RATIO0 + 8'(i), RATIO[31 - 8 * i -: 8]);
      cyc(40);
      edges(1'b0, n);
      chk(34'(n), 34'h0, "main pin before valid ratio");
      chk(34'(aux_out_o), 34'h0, "aux pin before valid ratio");
      r0 = relocks;
      wr(rcc_pkg::ADDR_RATIO3, RATIO[7:0]);
      cyc(2);
      chk(frac_n_value, exp_frac(RATIO, 3'h0, 2'h0), "frac after ratio");
      chk(34'(relocks - r0), 34'h1, "one relock per change");
      for (i = 0; i < 4; i++) rd_chk(rcc_pkg::ADDR_RATIO0 + 8'(i), RATIO[31 - 8 * i -: 8], "ratio byte");
      rd(rcc_pkg::ADDR_STATUS, d);
      chk(34'(d[rcc_pkg::STAT_VALID_BIT]), 34'h1, "ratio valid flag");
      r0 = relocks;
      wr(rcc_pkg::ADDR_RATIO3, RATIO[7:0]);
      cyc(2);
      chk(34'(relocks - r0), 34'h0, "no relock when value kept");
      wait_lock();
      edges(1'b0, n);
      chk(34'(n != 0), 34'h1, "main pin runs after valid ratio");
      $display("t_ratio done");
   endtask

   task automatic t_mod;
      int m;
      for (m = 0; m < 8; m++) begin
         wr(rcc_pkg::ADDR_CFG1, 8'(m << rcc_pkg::CFG1_RMOD_LSB));
         cyc(1);
         chk(frac_n_value, exp_frac(RATIO, 3'(m), 2'h0), "frac per modifier");
         rd_chk(rcc_pkg::ADDR_RATIO3, RATIO[7:0], "stored ratio kept");
      end
      wr(rcc_pkg::ADDR_CFG1, 8'h00);
      $display("t_mod done");
   endtask

   task automatic t_div;
      int d;
      for (d = 0; d < 4; d++) begin
         wr(rcc_pkg::ADDR_FUNC_CFG, 8'(d << rcc_pkg::FUNC_DIV_LSB));
         cyc(1);
         chk(frac_n_value, exp_frac(RATIO, 3'h0, 2'(d)), "frac per divider");
      end
      wr(rcc_pkg::ADDR_CFG1, 8'(1 << rcc_pkg::CFG1_RMOD_LSB));
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'(2 << rcc_pkg::FUNC_DIV_LSB));
      cyc(1);
      chk(frac_n_value, exp_frac(RATIO, 3'h1, 2'h2), "modifier with divider");
      wr(rcc_pkg::ADDR_CFG1, 8'h00);
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'h00);
      $display("t_div done");
   endtask

   task automatic t_main;
      int n;
      wait_lock();
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'(1 << rcc_pkg::OUT_MAIN_DIS_BIT));
      cyc(20);
      chk(34'(clk_out_oe), 34'h0, "main pin released");
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'h00);
      cyc(20);
      chk(34'(clk_out_oe), 34'h1, "main pin driven again");
      hold_unlock = 1'b1;
      cyc(20);
      edges(1'b0, n);
      chk(34'(n) + 34'(clk_out_o), 34'h0, "main held low while unlocked");
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'(1 << rcc_pkg::FUNC_ALLOW_BIT));
      cyc(20);
      edges(1'b0, n);
      chk(34'(n != 0), 34'h1, "main follows while unlocked");
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'h00);
      hold_unlock = 1'b0;
      wait_lock();
      $display("t_main done");
   endtask

   task automatic t_aux;
      int n;
      edges(1'b1, n);
      chk(34'(n != 0), 34'h1, "aux carries reference");
      wr(rcc_pkg::ADDR_CFG1, 8'h01 << rcc_pkg::CFG1_AUX_LSB);
      cyc(10);
      edges(1'b1, n);
      chk(34'(n != 0), 34'h1, "aux reference on second code");
      wr(rcc_pkg::ADDR_CFG1, 8'(rcc_pkg::AUX_SRC_SYNTH) << rcc_pkg::CFG1_AUX_LSB);
      cyc(10);
      edges(1'b1, n);
      chk(34'(n != 0), 34'h1, "aux carries synth copy");
      wr(rcc_pkg::ADDR_CFG1, 8'(rcc_pkg::AUX_SRC_LOCK) << rcc_pkg::CFG1_AUX_LSB);
      cyc(10);
      chk(34'({aux_out_o, aux_out_oe}), 34'h1, "push-pull lock, locked");
      hold_unlock = 1'b1;
      cyc(10);
      chk(34'({aux_out_o, aux_out_oe}), 34'h3, "push-pull lock, unlocked");
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'(1 << rcc_pkg::FUNC_STYLE_BIT));
      cyc(10);
      chk(34'({aux_out_o, aux_out_oe}), 34'h1, "open drain lock, unlocked");
      hold_unlock = 1'b0;
      wait_lock();
      chk(34'(aux_out_oe), 34'h0, "open drain lock, locked");
      wr(rcc_pkg::ADDR_FUNC_CFG, 8'h00);
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'(1 << rcc_pkg::OUT_AUX_DIS_BIT));
      cyc(5);
      chk(34'(aux_out_oe), 34'h0, "lock pin released");
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'h00);
      wr(rcc_pkg::ADDR_CFG1, 8'h00);
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'(1 << rcc_pkg::OUT_AUX_DIS_BIT));
      cyc(20);
      chk(34'({aux_out_oe, clk_out_oe}), 34'h1, "aux pin released alone");
      wr(rcc_pkg::ADDR_OUT_CTRL, 8'h00);
      $display("t_aux done");
   endtask

   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_ratio();
      t_mod();
      t_div();
      t_main();
      t_aux();
      results();
   end
endmodule
